// ===== src/cif_irq_flags.sv
// Notes on behaviour
// R1: status register ignores bus writes
// R2: pulse on every set condition, flag regardless; the idle flag, bit 14, never pulses
// R3: compare timer events need timer run, hall events need it only in hall mode
// R4: capture events pass with timer stopped
// R5: rising flags set on up-match or rise
// R6: falling flags set on down-match or fall
// R7: bit 6 on one-match counting down
// R8: bit 7 on period-match counting up
// R9: bits 8, 9 on aux compare, period
// R10: trap flag set by pin or software
// R11: trap state follows flag, clears on sync
// R12: trap state forces outputs passive
// R13: bits 13, 12 on wrong, correct hall
// R14: auto idle with wrong hall, clears pattern
// R15: bit 15 on pattern shadow transfer
// R16: set register writes set flags, pulse
// R17: set bit 10 sets flag and state
// R18: set bit 11 triggers hall compare
// R19: clear register writes clear flags
// R20: trap clear ignored while pin trapping
// R21: clear bit 11 reserved, reads zero
// R22: pulse only when event enabled
// R23: node pointer selects one of four outputs
// R24: requests on same output are ORed
// R25: hardware set beats software clear
`timescale 1ns/100ps
`default_nettype none
`include "cif_params.svh"
module cif_irq_flags
   import cif_pkg::*;
#(
   parameter int CHANNELS = 3
)
(
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [8:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [8:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // event sources from timer logic, same clock
   input wire logic main_timer_run,
   input wire logic aux_timer_run,
   input wire logic count_direction,
   input wire logic capture_mode,
   input wire logic hall_mode,
   input wire logic [CHANNELS-1:0] channel_compare_match,
   input wire logic main_one_match,
   input wire logic main_period_match,
   input wire logic aux_compare_match,
   input wire logic aux_period_match,
   input wire logic correct_hall_event,
   input wire logic wrong_hall_event,
   input wire logic pattern_shadow_transfer,
   input wire logic trap_sync_event,
   // pins
   input wire logic [CHANNELS-1:0] channel_capture_input,
   input wire logic trap_input_n,
   // outputs
   input wire logic [2*CHANNELS+1:0] pwm_outputs_in,
   output logic [2*CHANNELS+1:0] pwm_outputs,
   output logic [2*CHANNELS-1:0] active_output_pattern,
   output logic sw_hall_compare,
   output logic service_request_0,
   output logic service_request_1,
   output logic service_request_2,
   output logic service_request_3
);
   // the flag layout is fixed, so other channel counts are refused
   if (CHANNELS != 3)
   begin : g_bad_channels
      $error("cif_irq_flags: six flag slots serve exactly three channels");
   end

   localparam int NO = 2 * CHANNELS + 2;

   logic [15:0] event_flag_q;
   logic [15:0] event_enable_q;
   logic [15:0] node_pointer_q;
   logic [2:0] trap_control_q;
   logic [NO-1:0] passive_level_q;
   logic [2*CHANNELS-1:0] output_pattern_shadow_q;
   logic [2*CHANNELS-1:0] pattern_q;

   // pin synchronisers: stage two is read, and capture stage three too for edge detection
   logic [CHANNELS-1:0] cap_s1_q, cap_s2_q, cap_s3_q;
   logic trap_s1_q, trap_s2_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cap_s1_q <= '0;
         cap_s2_q <= '0;
         cap_s3_q <= '0;
         trap_s1_q <= 1'b1;
         trap_s2_q <= 1'b1;
      end
      else
      begin
         cap_s1_q <= channel_capture_input;
         cap_s2_q <= cap_s1_q;
         cap_s3_q <= cap_s2_q;
         trap_s1_q <= trap_input_n;
         trap_s2_q <= trap_s1_q;
      end
   end

   // axi write channel: address and data latched independently
   logic aw_have_q, w_have_q;
   logic [8:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_go, wr_known;
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 9'h000;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CIF_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? CIF_RESP_OKAY : CIF_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // decoded write strobes, low two byte lanes carry the 16-bit registers
   logic [6:0] wa;
   logic [15:0] wmask, wval;
   assign wa = aw_addr_q[8:2];
   assign wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   assign wval = w_data_q[15:0] & wmask;
   assign wr_known = (wa == `CIF_OFF_FLAGS) || (wa == `CIF_OFF_SET)
      || (wa == `CIF_OFF_CLEAR) || (wa == `CIF_OFF_ENABLE)
      || (wa == `CIF_OFF_NODE) || (wa == `CIF_OFF_TRAP_CTRL)
      || (wa == `CIF_OFF_PASSIVE) || (wa == `CIF_OFF_PATTERN);
   logic [15:0] sw_set, sw_clr;
   // the flag register address takes no write at all
   assign sw_set = (wr_go && wa == `CIF_OFF_SET) ? wval : 16'h0000; // R16 R1
   assign sw_clr = (wr_go && wa == `CIF_OFF_CLEAR) ? wval : 16'h0000; // R19
   assign sw_hall_compare = sw_set[`CIF_B_TRAP_STATE]; // R18

   // configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         event_enable_q <= `CIF_RST_ENABLE;
         node_pointer_q <= `CIF_RST_NODE;
         trap_control_q <= 3'(`CIF_RST_TRAP_CTRL);
         passive_level_q <= NO'(`CIF_RST_PASSIVE);
         output_pattern_shadow_q <= '0;
      end
      else if (wr_go)
      begin
         if (wa == `CIF_OFF_ENABLE)
            event_enable_q <= (event_enable_q & ~wmask) | (wval & 16'hf7ff);
         if (wa == `CIF_OFF_NODE)
            node_pointer_q <= (node_pointer_q & ~wmask) | (wval & 16'h3fff);
         if (wa == `CIF_OFF_TRAP_CTRL && w_strb_q[0])
            trap_control_q <= w_data_q[2:0];
         if (wa == `CIF_OFF_PASSIVE && w_strb_q[0])
            passive_level_q <= w_data_q[NO-1:0];
         if (wa == `CIF_OFF_PATTERN && w_strb_q[0])
            output_pattern_shadow_q <= w_data_q[2*CHANNELS-1:0];
      end
   end

   // hardware set conditions
   logic [15:0] hw_set, set_cond;
   logic cmp_ok, aux_ok;
   logic [CHANNELS-1:0] rise, fall;
   assign rise = cap_s2_q & ~cap_s3_q;
   assign fall = ~cap_s2_q & cap_s3_q;
   // compare and period events are gated by run bits, hall events only in hall mode, captures never
   assign cmp_ok = main_timer_run; // R3
   assign aux_ok = aux_timer_run; // R3
   logic trap_pin_active;
   assign trap_pin_active = !trap_s2_q && trap_control_q[`CIF_B_TRAP_PIN_EN];
   always_comb
   begin
      hw_set = 16'h0000;
      for (int c = 0; c < CHANNELS; c++)
      begin
         if (capture_mode)
         begin
            hw_set[2*c] = rise[c]; // R5 R4
            hw_set[2*c+1] = fall[c]; // R6 R4
         end
         else
         begin
            hw_set[2*c] = cmp_ok && channel_compare_match[c] && !count_direction; // R5
            hw_set[2*c+1] = cmp_ok && channel_compare_match[c] && count_direction; // R6
         end
      end
      hw_set[`CIF_B_ONE_MATCH] = cmp_ok && main_one_match && count_direction; // R7
      hw_set[`CIF_B_PERIOD] = cmp_ok && main_period_match && !count_direction; // R8
      hw_set[`CIF_B_AUX_CMP] = aux_ok && aux_compare_match; // R9
      hw_set[`CIF_B_AUX_PER] = aux_ok && aux_period_match; // R9
      hw_set[`CIF_B_TRAP_FLAG] = trap_pin_active; // R10
      hw_set[`CIF_B_CORRECT_HALL] = correct_hall_event && (!hall_mode || cmp_ok); // R13
      hw_set[`CIF_B_WRONG_HALL] = wrong_hall_event && (!hall_mode || cmp_ok); // R13
      hw_set[`CIF_B_IDLE] = hw_set[`CIF_B_WRONG_HALL]
         && event_enable_q[`CIF_B_AUTO_HALT]; // R14
      hw_set[`CIF_B_PATTERN_XFER] = pattern_shadow_transfer; // R15
   end
   // software bit 11 is a hall compare, not a flag set
   assign set_cond = hw_set | (sw_set & 16'hf7ff)
      | {1'b0, sw_set[`CIF_B_WRONG_HALL] && event_enable_q[`CIF_B_AUTO_HALT], 14'h0000}; // R14

   // status flags: set beats clear, trap flag clear guarded
   logic [15:0] clr_eff;
   always_comb
   begin
      clr_eff = sw_clr & 16'hf7ff; // R21
      if (trap_pin_active)
         clr_eff[`CIF_B_TRAP_FLAG] = 1'b0; // R20
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         event_flag_q <= `CIF_RST_FLAGS;
      else
      begin
         event_flag_q <= ((event_flag_q & ~clr_eff) | set_cond) & 16'hf7ff; // R25 R16 R19
         // latch mode 0 drops the flag as soon as the pin trap goes away
         if (!trap_control_q[`CIF_B_TRAP_LATCH] && !trap_pin_active
             && !sw_set[`CIF_B_TRAP_FLAG])
            event_flag_q[`CIF_B_TRAP_FLAG] <= 1'b0; // R10
         // trap state: set by flag, held until selected sync
         if (set_cond[`CIF_B_TRAP_FLAG] || event_flag_q[`CIF_B_TRAP_FLAG])
            event_flag_q[`CIF_B_TRAP_STATE] <= 1'b1; // R11 R17
         else if (!trap_control_q[`CIF_B_TRAP_SYNC] || trap_sync_event)
            event_flag_q[`CIF_B_TRAP_STATE] <= 1'b0; // R11
         else
            event_flag_q[`CIF_B_TRAP_STATE] <= event_flag_q[`CIF_B_TRAP_STATE];
      end
   end

   // active pattern: loaded on transfer, cleared while idle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pattern_q <= '0;
      else if (event_flag_q[`CIF_B_IDLE])
         pattern_q <= '0; // R14
      else if (pattern_shadow_transfer)
         pattern_q <= output_pattern_shadow_q; // R15
   end
   assign active_output_pattern = pattern_q;

   // passive forcing; registered so outputs come from flip-flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pwm_outputs <= '0;
      else if (event_flag_q[`CIF_B_TRAP_STATE] || event_flag_q[`CIF_B_IDLE])
         pwm_outputs <= passive_level_q; // R12 R14
      else
         pwm_outputs <= pwm_outputs_in;
   end

   // interrupt pulses: every set condition except idle bit 14, independent of flag value
   logic [15:0] pulse;
   assign pulse = set_cond & event_enable_q & 16'hb7ff; // R2 R22
   logic [1:0] node_sel [16];
   always_comb
   begin
      for (int b = 0; b < 16; b++)
         node_sel[b] = 2'b00;
      for (int c = 0; c < CHANNELS; c++)
      begin
         node_sel[2*c] = node_pointer_q[2*c +: 2];
         node_sel[2*c+1] = node_pointer_q[2*c +: 2];
      end
      node_sel[6] = node_pointer_q[11:10];
      node_sel[7] = node_pointer_q[11:10];
      node_sel[8] = node_pointer_q[13:12];
      node_sel[9] = node_pointer_q[13:12];
      node_sel[10] = node_pointer_q[9:8];
      node_sel[13] = node_pointer_q[9:8];
      node_sel[12] = node_pointer_q[7:6];
      node_sel[15] = node_pointer_q[7:6];
   end
   logic [3:0] req [16];
   genvar g;
   generate
      for (g = 0; g < 16; g++)
      begin : g_route
         cif_node_router u_route
         (
            .pulse(pulse[g]),
            .node(node_sel[g]), // R23
            .req(req[g])
         );
      end
   endgenerate
   logic [3:0] sr_d;
   always_comb
   begin
      sr_d = 4'h0;
      for (int b = 0; b < 16; b++)
         sr_d = sr_d | req[b]; // R24
   end
   // one-cycle registered pulses
   logic [3:0] sr_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sr_q <= 4'h0;
      else
         sr_q <= sr_d;
   end
   assign service_request_0 = sr_q[0];
   assign service_request_1 = sr_q[1];
   assign service_request_2 = sr_q[2];
   assign service_request_3 = sr_q[3];

   // axi read channel, one cycle answer
   logic [15:0] rd_val;
   logic rd_known;
   always_comb
   begin
      rd_val = 16'h0000;
      rd_known = 1'b1;
      case (s_axi_araddr[8:2])
         `CIF_OFF_FLAGS: rd_val = event_flag_q;
         `CIF_OFF_SET: rd_val = 16'h0000;
         `CIF_OFF_CLEAR: rd_val = 16'h0000;
         `CIF_OFF_ENABLE: rd_val = event_enable_q;
         `CIF_OFF_NODE: rd_val = node_pointer_q;
         `CIF_OFF_TRAP_CTRL: rd_val = {13'h0000, trap_control_q};
         `CIF_OFF_PASSIVE: rd_val = {8'h00, passive_level_q};
         `CIF_OFF_PATTERN: rd_val = {2'b00, pattern_q, 2'b00, output_pattern_shadow_q};
         default: rd_known = 1'b0;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= CIF_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_val};
         s_axi_rresp <= rd_known ? CIF_RESP_OKAY : CIF_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule : cif_irq_flags
`default_nettype wire

// ===== src/cif_params.svh
`ifndef CIF_PARAMS_SVH
`define CIF_PARAMS_SVH
// register word indices; the byte address is four times the index
`define CIF_OFF_FLAGS 7'h50
`define CIF_OFF_SET 7'h52
`define CIF_OFF_CLEAR 7'h54
`define CIF_OFF_ENABLE 7'h58
`define CIF_OFF_NODE 7'h56
`define CIF_OFF_TRAP_CTRL 7'h60
`define CIF_OFF_PASSIVE 7'h44
`define CIF_OFF_PATTERN 7'h4c
// reset values
`define CIF_RST_FLAGS 16'h0000
`define CIF_RST_ENABLE 16'h0000
`define CIF_RST_NODE 16'h3940
`define CIF_RST_TRAP_CTRL 16'h0000
`define CIF_RST_PASSIVE 16'h0000
// status bit positions
`define CIF_B_ONE_MATCH 6
`define CIF_B_PERIOD 7
`define CIF_B_AUX_CMP 8
`define CIF_B_AUX_PER 9
`define CIF_B_TRAP_FLAG 10
`define CIF_B_TRAP_STATE 11
`define CIF_B_CORRECT_HALL 12
`define CIF_B_WRONG_HALL 13
`define CIF_B_IDLE 14
`define CIF_B_PATTERN_XFER 15
// enable register bit of auto idle
`define CIF_B_AUTO_HALT 14
// trap control bits
`define CIF_B_TRAP_LATCH 0
`define CIF_B_TRAP_PIN_EN 1
`define CIF_B_TRAP_SYNC 2
`endif

// ===== src/cif_pkg.sv
package cif_pkg;
   typedef enum logic [1:0] {CIF_RESP_OKAY = 2'b00, CIF_RESP_SLVERR = 2'b10} cif_resp_t;
   typedef logic [15:0] cif_word_t;
endpackage : cif_pkg

// ===== src/cif_node_router.sv
`timescale 1ns/100ps
`default_nettype none
// routes one enabled event pulse onto one of four service requests
module cif_node_router
(
   input wire logic pulse,
   input wire logic [1:0] node,
   output logic [3:0] req
);
   // decode the 2-bit node pointer into a one-hot request
   always_comb
   begin
      req = 4'h0;
      req[node] = pulse;
   end
endmodule : cif_node_router
`default_nettype wire

// ===== testbench/cif_sr_sink.sv
`timescale 1ns/100ps
`default_nettype none
// stands in for the system interrupt controller: it only tallies
// request pulses per line, so a lost or doubled pulse shows in the count
module cif_sr_sink
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] req
);
   int unsigned hits [4];
   // every cycle a line is high counts as one request
   always @(posedge aclk)
      for (int i = 0; i < 4; i++)
         if (aresetn && req[i] === 1'b1)
            hits[i] <= hits[i] + 1;
endmodule : cif_sr_sink
`default_nettype wire

// ===== testbench/cif_flag_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "cif_params.svh"
// port-level checker; event causes are traced through short histories
module cif_flag_chk
#(
   parameter int CHANNELS = 3
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [8:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic main_timer_run,
   input wire logic aux_timer_run,
   input wire logic capture_mode,
   input wire logic [CHANNELS-1:0] channel_compare_match,
   input wire logic main_one_match,
   input wire logic main_period_match,
   input wire logic aux_compare_match,
   input wire logic aux_period_match,
   input wire logic correct_hall_event,
   input wire logic wrong_hall_event,
   input wire logic pattern_shadow_transfer,
   input wire logic [CHANNELS-1:0] channel_capture_input,
   input wire logic trap_input_n,
   input wire logic sw_hall_compare,
   input wire logic service_request_0,
   input wire logic service_request_1,
   input wire logic service_request_2,
   input wire logic service_request_3
);
   logic [CHANNELS-1:0] cap_q;
   logic [8:0] rd_addr_q;
   logic [5:0] all_q, nomain_q, noaux_q;
   logic main_ev, aux_ev, base_ev, sr_any;
   // a trap pin held low is a standing cause, it may request every cycle
   assign main_ev = |channel_compare_match | main_one_match | main_period_match;
   assign aux_ev = aux_compare_match | aux_period_match;
   assign base_ev = (s_axi_wvalid & s_axi_wready) | (channel_capture_input != cap_q)
      | !trap_input_n | correct_hall_event | wrong_hall_event | pattern_shadow_transfer;
   assign sr_any = service_request_0 | service_request_1 | service_request_2 | service_request_3;
   always_ff @(posedge aclk)
      cap_q <= channel_capture_input;
   // six cycles cover the slowest path, a pin edge through its synchroniser
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         all_q <= '0;
         nomain_q <= '0;
         noaux_q <= '0;
      end
      else
      begin
         all_q <= {all_q[4:0], base_ev | main_ev | aux_ev};
         nomain_q <= {nomain_q[4:0], base_ev | aux_ev};
         noaux_q <= {noaux_q[4:0], base_ev | main_ev};
      end
   end
   // address of the read under way
   always_ff @(posedge aclk)
      if (s_axi_arvalid && s_axi_arready)
         rd_addr_q <= s_axi_araddr;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sr_has_cause_a: assert property (sr_any |-> all_q != 6'h00)
      else $error("service request without a recent cause");
   main_run_gate_a: assert property (
      main_ev && !main_timer_run && !capture_mode && !(base_ev | aux_ev) && nomain_q == 6'h00
      |=> !sr_any) else $error("main timer event requested while stopped");
   aux_run_gate_a: assert property (
      aux_ev && !aux_timer_run && !(base_ev | main_ev) && noaux_q == 6'h00
      |=> !sr_any) else $error("aux timer event requested while stopped");
   hall_compare_pulse_a: assert property (sw_hall_compare |-> ##[0:1] s_axi_bvalid)
      else $error("hall compare pulse outside a write");
   wo_read_zero_a: assert property (
      s_axi_rvalid && (rd_addr_q[8:2] == `CIF_OFF_SET || rd_addr_q[8:2] == `CIF_OFF_CLEAR)
      |-> s_axi_rdata == 32'h0) else $error("write-only register read nonzero");
   unmapped_err_a: assert property (s_axi_rvalid && rd_addr_q[8:6] == 3'h0
      |-> s_axi_rresp == 2'b10) else $error("unmapped read not refused");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   resp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held after accept");

   cover property (service_request_3);
   cover property (sw_hall_compare);
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : cif_flag_chk
bind cif_irq_flags cif_flag_chk #(.CHANNELS(CHANNELS)) cif_flag_chk_i (.*);
`default_nettype wire

// ===== testbench/tb_cif_irq_flags.sv
`timescale 1ns/100ps
`default_nettype none
`include "cif_params.svh"
module tb_cif_irq_flags
   import cif_pkg::*;
;
   // per event line: flag bit, request line at reset pointers, count direction
   localparam int FBIT [10] = '{0, 3, 4, 6, 7, 8, 9, 12, 13, 15};
   localparam int FSR [10] = '{0, 0, 0, 2, 2, 3, 3, 1, 1, 1};
   localparam logic [9:0] FDIR = 10'h00a;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [8:0] s_axi_awaddr = 9'h000, s_axi_araddr = 9'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic main_timer_run = 1'b1, aux_timer_run = 1'b1, count_direction = 1'b0;
   logic capture_mode = 1'b0, hall_mode = 1'b0, trap_sync_event = 1'b0, trap_input_n = 1'b1;
   logic [2:0] channel_capture_input = 3'h0;
   logic [9:0] evs = 10'h000;
   wire logic [2:0] channel_compare_match = evs[2:0];
   wire logic main_one_match = evs[3];
   wire logic main_period_match = evs[4];
   wire logic aux_compare_match = evs[5];
   wire logic aux_period_match = evs[6];
   wire logic correct_hall_event = evs[7];
   wire logic wrong_hall_event = evs[8];
   wire logic pattern_shadow_transfer = evs[9];
   logic [7:0] pwm_outputs_in = 8'h00, pwm_outputs;
   logic [5:0] active_output_pattern;
   logic sw_hall_compare, service_request_0, service_request_1, service_request_2;
   logic service_request_3;
   int fails = 0, samples_checked = 0, cycles = 0, hall_seen = 0;
   int unsigned snap [4];
   logic [31:0] rd;
   logic [1:0] rsp;

   always #12.5 aclk = ~aclk;

   cif_irq_flags cif_irq_flags_i (.*);
   cif_sr_sink cif_sr_sink_i (.aclk, .aresetn,
      .req({service_request_3, service_request_2, service_request_1, service_request_0}));

   // hall compare pulses are tallied; the ceiling stops a hung handshake
   always @(posedge aclk)
   begin
      cycles++;
      if (sw_hall_compare === 1'b1)
         hall_seen++;
      if (cycles == 20000)
      begin
         fails++;
         close_out;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic settle;
      repeat (8) @(posedge aclk);
   endtask : settle

   // address and data offered together, each released once taken
   task automatic axi_wr(input logic [6:0] a, input logic [15:0] d);
      bit got;
      got = 0;
      @(posedge aclk);
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!got)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            got = 1;
            s_axi_bready <= 1'b0;
         end
      end
      settle;
   endtask : axi_wr

   task automatic axi_rd(input logic [6:0] a);
      bit got;
      got = 0;
      @(posedge aclk);
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!got)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            got = 1;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
   endtask : axi_rd

   task automatic chk_flags(input logic [15:0] e);
      axi_rd(`CIF_OFF_FLAGS);
      check(rd, {16'h0000, e});
   endtask : chk_flags

   task automatic snap_sr;
      for (int i = 0; i < 4; i++)
         snap[i] = cif_sr_sink_i.hits[i];
   endtask : snap_sr

   // one nibble of e per request line: pulses expected since the snapshot
   task automatic chk_sr(input logic [15:0] e);
      for (int i = 0; i < 4; i++)
         check(32'(cif_sr_sink_i.hits[i] - snap[i]), {28'h0, e[4*i +: 4]});
   endtask : chk_sr

   task automatic pulse(input logic [9:0] m, input logic d);
      @(posedge aclk);
      evs <= m;
      count_direction <= d;
      @(posedge aclk);
      evs <= 10'h000;
      settle;
   endtask : pulse

   task automatic t_regs;
      chk_flags(16'h0000);
      axi_rd(7'h00);
      check(rsp, CIF_RESP_SLVERR);
      axi_rd(`CIF_OFF_SET);
      check(rd, 32'h0);
      axi_rd(`CIF_OFF_CLEAR);
      check(rd, 32'h0);
      axi_wr(`CIF_OFF_FLAGS, 16'hffff);
      chk_flags(16'h0000);
   endtask : t_regs

   // every event twice, so a set flag must not swallow the second request
   task automatic t_events;
      axi_wr(`CIF_OFF_ENABLE, 16'hb7ff);
      for (int k = 0; k < 10; k++)
      begin
         snap_sr;
         pulse(10'h001 << k, FDIR[k]);
         pulse(10'h001 << k, FDIR[k]);
         chk_sr(16'h0002 << (4 * FSR[k]));
         chk_flags(16'h0001 << FBIT[k]);
         axi_wr(`CIF_OFF_CLEAR, 16'h0001 << FBIT[k]);
         chk_flags(16'h0000);
      end
      snap_sr;
      pulse(10'h005, 1'b0);
      chk_sr(16'h0001);
      chk_flags(16'h0011);
      axi_wr(`CIF_OFF_CLEAR, 16'hf7ff);
   endtask : t_events

   task automatic t_gate;
      @(posedge aclk);
      main_timer_run <= 1'b0;
      aux_timer_run <= 1'b0;
      snap_sr;
      pulse(10'h001, 1'b0);
      pulse(10'h020, 1'b0);
      hall_mode <= 1'b1;
      pulse(10'h080, 1'b0);
      chk_sr(16'h0000);
      axi_wr(`CIF_OFF_CLEAR, 16'hf7ff);
      capture_mode <= 1'b1;
      snap_sr;
      channel_capture_input <= 3'h2;
      settle;
      chk_flags(16'h0004);
      channel_capture_input <= 3'h0;
      settle;
      chk_flags(16'h000c);
      chk_sr(16'h0002);
      capture_mode <= 1'b0;
      main_timer_run <= 1'b1;
      aux_timer_run <= 1'b1;
      axi_wr(`CIF_OFF_ENABLE, 16'h0000);
      snap_sr;
      pulse(10'h080, 1'b0);
      chk_sr(16'h0000);
      chk_flags(16'h100c);
      axi_wr(`CIF_OFF_CLEAR, 16'hf7ff);
   endtask : t_gate

   task automatic t_sw;
      int h;
      axi_wr(`CIF_OFF_ENABLE, 16'hb7ff);
      snap_sr;
      axi_wr(`CIF_OFF_SET, 16'h8081);
      chk_flags(16'h8081);
      chk_sr(16'h0111);
      h = hall_seen;
      axi_wr(`CIF_OFF_SET, 16'h0800);
      check(32'(hall_seen - h), 32'h1);
      chk_flags(16'h8081);
      axi_wr(`CIF_OFF_CLEAR, 16'h8081);
      chk_flags(16'h0000);
   endtask : t_sw

   task automatic t_trap;
      axi_wr(`CIF_OFF_PASSIVE, 16'h00a5);
      axi_wr(`CIF_OFF_TRAP_CTRL, 16'h0002);
      trap_input_n <= 1'b0;
      settle;
      chk_flags(16'h0c00);
      check(pwm_outputs, 32'ha5);
      axi_wr(`CIF_OFF_CLEAR, 16'h0400);
      chk_flags(16'h0c00);
      trap_input_n <= 1'b1;
      settle;
      chk_flags(16'h0000);
      check(pwm_outputs, 32'h00);
      axi_wr(`CIF_OFF_TRAP_CTRL, 16'h0005);
      axi_wr(`CIF_OFF_SET, 16'h0400);
      chk_flags(16'h0c00);
      axi_wr(`CIF_OFF_CLEAR, 16'h0400);
      chk_flags(16'h0800);
      trap_sync_event <= 1'b1;
      @(posedge aclk);
      trap_sync_event <= 1'b0;
      chk_flags(16'h0000);
   endtask : t_trap

   task automatic t_idle;
      axi_wr(`CIF_OFF_ENABLE, 16'hf7ff);
      axi_wr(`CIF_OFF_PATTERN, 16'h002a);
      pulse(10'h200, 1'b0);
      check(active_output_pattern, 32'h2a);
      pulse(10'h100, 1'b0);
      chk_flags(16'he000);
      check(active_output_pattern, 32'h00);
      check(pwm_outputs, 32'ha5);
      axi_wr(`CIF_OFF_CLEAR, 16'he000);
      chk_flags(16'h0000);
      axi_wr(`CIF_OFF_SET, 16'h2000);
      chk_flags(16'h6000);
   endtask : t_idle

   task automatic close_out;
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_events;
      t_gate;
      t_sw;
      t_trap;
      t_idle;
      close_out;
   end
endmodule : tb_cif_irq_flags
`default_nettype wire
